/* inc/tx_mac_client_status_cfg.svh */
`ifndef TX_MAC_CLIENT_STATUS_CFG_SVH
`define TX_MAC_CLIENT_STATUS_CFG_SVH
// ********************
// register byte offsets
// ********************
`define TXS_CTRL_OFS 12'h000
`define TXS_IRQ_STAT_OFS 12'h004
`define TXS_IRQ_MASK_OFS 12'h008
`define TXS_LAST_VEC_OFS 12'h00c
`define TXS_MGMT_OFS 12'h010
`define TXS_FRAME_CNT_OFS 12'h014
// ********************
// field positions
// ********************
`define TXS_CTRL_EN_BIT 0
`define TXS_CTRL_FCS_OFF_BIT 1
`define TXS_IRQ_DONE_BIT 0
`define TXS_IRQ_DISCARD_BIT 1
`define TXS_IRQ_VEC_BIT 2
`define TXS_MGMT_MDO_BIT 0
`define TXS_MGMT_OE_BIT 1
`define TXS_MGMT_MDC_BIT 2
`define TXS_MGMT_MDI_BIT 3
// ********************
// reset values, frame limits and deferral threshold
// ********************
`define TXS_CTRL_RST 2'h0
`define TXS_IRQ_RST 3'h0
`define TXS_MGMT_RST 3'h0
`define TXS_JUMBO_LIMIT 14'h05ee
`define TXS_MIN_FRAME 14'h0040
`define TXS_EXC_DEFER_CYC 16'h0400
`endif

/* inc/tx_mac_client_status_pkg.sv */
package tx_mac_client_status_pkg;
  // transmit statistics vector, bit 31 down to bit 0
  typedef struct packed {
    logic rsv31;
    logic short_nofcs;
    logic [2:0] rsv29_27;
    logic [2:0] rsv26_24;
    logic exc_defer;
    logic deferred;
    logic [13:0] byte_cnt;
    logic vlan;
    logic pause;
    logic underrun;
    logic jumbo;
    logic bad_fcs;
    logic bcast;
    logic mcast;
    logic ucast;
  } tx_statvec_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEFER = 3'h1,
    ST_READ = 3'h3,
    ST_FINISH = 3'h2
  } tx_state_e;
endpackage : tx_mac_client_status_pkg

/* logic/tx_mac_client_status.sv */
// Functional notes
// R01: stat valid strobe rises only while the whole vector describes the sent frame.
// R02: first read request only when fifo empty is low; later reads also need it low.
// R03: integrator ties read request to fifo read and fifo empty to our empty input.
// R04: vector bits 0-7: unicast, multicast, broadcast, bad fcs, jumbo, underrun, pause, vlan.
// R05: vector bits 21:8 hold the unsigned byte count of the frame.
// R06: bit 22 flags deferred transmission, bit 23 excessive deferral.
// R07: bits 24-26 reserved zero; bit 30 flags short frame sent with fcs disabled.
// R08: error-free frame gives a transmit-done pulse of exactly one cycle.
// R09: a transmit error such as underrun raises discard at the end of the frame.
// R10: client should skip its fifo read pointer to the next frame on discard.
// R11: management output enable is high whenever the management output is valid.
// R12: fifo empty while reading frame data is sent to the line as transmit error.
// R13: exactly one valid statistics vector per frame, done or discarded.
`timescale 1ns/10ps
`include "tx_mac_client_status_cfg.svh"

module tx_mac_client_status #(
  parameter logic [15:0] EXC_DEFER_CYC = `TXS_EXC_DEFER_CYC
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // client transmit fifo
  input wire logic [7:0] tx_fifodata,
  input wire logic tx_fifoavail,
  input wire logic tx_fifoeof,
  input wire logic tx_fifoempty,
  input wire logic tx_fifoctrl,
  output logic tx_fifo_rd,
  // line busy, transmission must wait
  input wire logic tx_defer_req,
  // frame status
  output logic tx_stat_valid,
  output tx_mac_client_status_pkg::tx_statvec_s tx_statvec,
  output logic tx_done,
  output logic tx_discard,
  // gmii transmit
  output logic [7:0] txd,
  output logic txen,
  output logic txer,
  // management pins
  input wire logic mdi,
  output logic mdo,
  output logic mdo_en,
  output logic mdc,
  // interrupt
  output logic irq
);

  // ********************
  // state
  // ********************
  tx_mac_client_status_pkg::tx_state_e state_r;
  tx_mac_client_status_pkg::tx_statvec_s acc_r;
  logic [1:0] ctrl_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [31:0] frame_cnt_r;
  logic [15:0] defer_cnt_r;
  logic [2:0] mgmt_r;
  logic bcast_ok_r;
  logic vlan_hi_r;
  logic underrun_r;

  logic apb_wr;
  logic apb_setup;
  logic [2:0] irq_set;
  logic byte_taken;
  logic last_byte;
  logic frame_end;

  function automatic logic [13:0] sat_inc(input logic [13:0] v);
    sat_inc = (v == 14'h3fff) ? v : v + 14'h0001;
  endfunction : sat_inc

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pready & pwrite;
  // a byte is popped at every edge where the read request is high
  assign byte_taken = (state_r == tx_mac_client_status_pkg::ST_READ) & tx_fifo_rd;
  assign last_byte = byte_taken & tx_fifoeof;
  // reads alternate with idle cycles, so empty always reflects the last pop
  assign frame_end = last_byte |
    ((state_r == tx_mac_client_status_pkg::ST_READ) & ~tx_fifo_rd & tx_fifoempty); // [R12]
  // an underrun ends the frame without its last byte, a clean end pops it
  assign irq_set = {frame_end, frame_end & ~last_byte, last_byte};

  // ********************
  // transmit sequencer
  // ********************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= tx_mac_client_status_pkg::ST_IDLE;
      defer_cnt_r <= 16'h0000;
    end else if (ce) begin
      case (state_r)
        tx_mac_client_status_pkg::ST_IDLE: begin
          defer_cnt_r <= 16'h0000;
          if (ctrl_r[`TXS_CTRL_EN_BIT] & tx_fifoavail & ~tx_fifoempty) begin
            state_r <= tx_defer_req ? tx_mac_client_status_pkg::ST_DEFER : tx_mac_client_status_pkg::ST_READ;
          end
        end
        tx_mac_client_status_pkg::ST_DEFER: begin
          if (defer_cnt_r != 16'hffff) begin
            defer_cnt_r <= defer_cnt_r + 16'h0001;
          end
          if (~tx_defer_req) begin
            state_r <= tx_mac_client_status_pkg::ST_READ;
          end
        end
        tx_mac_client_status_pkg::ST_READ: begin
          if (frame_end) begin
            state_r <= tx_mac_client_status_pkg::ST_FINISH;
          end
        end
        tx_mac_client_status_pkg::ST_FINISH: begin
          state_r <= tx_mac_client_status_pkg::ST_IDLE;
        end
        default: begin
          state_r <= tx_mac_client_status_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ********************
  // fifo read request
  // ********************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_fifo_rd <= 1'b0;
    end else if (ce) begin
      // one pop then one look at empty, trading half rate for exact empty tracking
      tx_fifo_rd <= (state_r == tx_mac_client_status_pkg::ST_READ) & ~tx_fifo_rd &
        ~tx_fifoempty & ~frame_end; // [R02]
    end
  end

  // ********************
  // gmii transmit
  // ********************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txd <= 8'h00;
      txen <= 1'b0;
      txer <= 1'b0;
    end else if (ce) begin
      if (byte_taken) begin
        txd <= tx_fifodata;
      end
      // enable holds through the frame, the line sees each byte but the last twice at half rate
      if (byte_taken) begin
        txen <= 1'b1;
      end else if (frame_end | (state_r != tx_mac_client_status_pkg::ST_READ)) begin
        txen <= 1'b0;
      end
      txer <= frame_end & ~last_byte; // [R12]
    end
  end

  // ********************
  // frame classification
  // ********************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
      bcast_ok_r <= 1'b0;
      vlan_hi_r <= 1'b0;
      underrun_r <= 1'b0;
    end else if (ce) begin
      if (state_r == tx_mac_client_status_pkg::ST_IDLE) begin
        acc_r <= '0;
        acc_r.pause <= tx_fifoctrl; // [R04]
        bcast_ok_r <= 1'b1;
        vlan_hi_r <= 1'b0;
        underrun_r <= 1'b0;
      end else if (state_r == tx_mac_client_status_pkg::ST_DEFER) begin
        acc_r.deferred <= 1'b1; // [R06]
        if (defer_cnt_r >= EXC_DEFER_CYC) begin
          acc_r.exc_defer <= 1'b1; // [R06]
        end
      end else if (byte_taken) begin
        acc_r.byte_cnt <= sat_inc(acc_r.byte_cnt); // [R05]
        if (acc_r.byte_cnt == 14'h0000) begin
          acc_r.mcast <= tx_fifodata[0]; // [R04]
        end
        if (acc_r.byte_cnt < 14'h0006) begin
          bcast_ok_r <= bcast_ok_r & (tx_fifodata == 8'hff);
        end
        if (acc_r.byte_cnt == 14'h000c) begin
          vlan_hi_r <= (tx_fifodata == 8'h81);
        end
        if (acc_r.byte_cnt == 14'h000d) begin
          acc_r.vlan <= vlan_hi_r & (tx_fifodata == 8'h00); // [R04]
        end
      end
      if (frame_end) begin
        underrun_r <= ~last_byte;
      end
    end
  end

  // ********************
  // frame report
  // ********************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_statvec <= '0;
      tx_stat_valid <= 1'b0;
      tx_done <= 1'b0;
      tx_discard <= 1'b0;
    end else if (ce) begin
      tx_stat_valid <= 1'b0;
      tx_done <= 1'b0;
      tx_discard <= 1'b0;
      if (state_r == tx_mac_client_status_pkg::ST_FINISH) begin
        // vector and strobe load together so no partial vector is ever flagged
        tx_statvec <= acc_r; // [R01]
        tx_statvec.bcast <= bcast_ok_r & (acc_r.byte_cnt >= 14'h0006); // [R04]
        tx_statvec.mcast <= acc_r.mcast & ~(bcast_ok_r & (acc_r.byte_cnt >= 14'h0006)); // [R04]
        tx_statvec.ucast <= ~acc_r.mcast; // [R04]
        tx_statvec.bad_fcs <= 1'b0; // [R04]
        tx_statvec.jumbo <= acc_r.byte_cnt > `TXS_JUMBO_LIMIT; // [R04]
        tx_statvec.underrun <= underrun_r; // [R04]
        tx_statvec.rsv26_24 <= 3'h0; // [R07]
        tx_statvec.rsv29_27 <= 3'h0;
        tx_statvec.rsv31 <= 1'b0;
        tx_statvec.short_nofcs <= ctrl_r[`TXS_CTRL_FCS_OFF_BIT] &
          (acc_r.byte_cnt < `TXS_MIN_FRAME); // [R07]
        tx_stat_valid <= 1'b1; // [R01] [R13]
        tx_done <= ~underrun_r; // [R08]
        tx_discard <= underrun_r; // [R09]
      end
    end
  end

  // ********************
  // management pins
  // ********************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mdo <= 1'b0;
      mdo_en <= 1'b0;
      mdc <= 1'b0;
    end else if (ce) begin
      // output and its enable change on the same edge, never valid without enable
      mdo <= mgmt_r[`TXS_MGMT_MDO_BIT] & mgmt_r[`TXS_MGMT_OE_BIT]; // [R11]
      mdo_en <= mgmt_r[`TXS_MGMT_OE_BIT]; // [R11]
      mdc <= mgmt_r[`TXS_MGMT_MDC_BIT];
    end
  end

  // ********************
  // software registers
  // ********************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `TXS_CTRL_RST;
      irq_mask_r <= `TXS_IRQ_RST;
      mgmt_r <= `TXS_MGMT_RST;
    end else if (ce && apb_wr && !pslverr) begin
      if (paddr == `TXS_CTRL_OFS) begin
        ctrl_r <= pwdata[1:0];
      end else if (paddr == `TXS_IRQ_MASK_OFS) begin
        irq_mask_r <= pwdata[2:0];
      end else if (paddr == `TXS_MGMT_OFS) begin
        mgmt_r <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= `TXS_IRQ_RST;
    end else if (ce) begin
      // a new event in the clearing cycle survives
      if (apb_wr && (paddr == `TXS_IRQ_STAT_OFS)) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_cnt_r <= 32'h00000000;
    end else if (ce && frame_end) begin
      frame_cnt_r <= frame_cnt_r + 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ********************
  // apb answer
  // ********************
  // data is fetched in the setup cycle so every access phase lasts one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_setup) begin
        if (paddr == `TXS_CTRL_OFS) begin
          prdata <= {30'h00000000, ctrl_r};
        end else if (paddr == `TXS_IRQ_STAT_OFS) begin
          prdata <= {29'h00000000, irq_stat_r};
        end else if (paddr == `TXS_IRQ_MASK_OFS) begin
          prdata <= {29'h00000000, irq_mask_r};
        end else if (paddr == `TXS_LAST_VEC_OFS) begin
          prdata <= tx_statvec;
        end else if (paddr == `TXS_MGMT_OFS) begin
          prdata <= {28'h0000000, mdi, mgmt_r};
        end else if (paddr == `TXS_FRAME_CNT_OFS) begin
          prdata <= frame_cnt_r;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule : tx_mac_client_status

/* tb/tx_mac_client_status_checker.sv */
`timescale 1ns/10ps
module tx_mac_client_status_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // watched ports
  input wire logic tx_fifoempty,
  input wire logic tx_fifo_rd,
  input wire logic tx_stat_valid,
  input wire tx_mac_client_status_pkg::tx_statvec_s tx_statvec,
  input wire logic tx_done,
  input wire logic tx_discard,
  input wire logic txer,
  input wire logic mdo,
  input wire logic mdo_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence outcome_s;
    tx_done ^ tx_discard;
  endsequence
  sequence strobe_end_s;
    tx_stat_valid ##1 !tx_stat_valid;
  endsequence
  rd_gate_a: assert property (tx_fifo_rd |-> !$past(tx_fifoempty))
    else $error("fifo read after empty");
  vec_hold_a: assert property (!$stable(tx_statvec) |-> tx_stat_valid)
    else $error("vector moved without strobe");
  rsv_zero_a: assert property (tx_stat_valid |-> tx_statvec.rsv26_24 == 3'h0)
    else $error("reserved bits set");
  under_flag_a: assert property (tx_stat_valid |-> tx_statvec.underrun == tx_discard)
    else $error("underrun flag disagrees");
  done_pulse_a: assert property (tx_done |=> !tx_done)
    else $error("done longer than a cycle");
  one_vec_a: assert property (tx_stat_valid |-> outcome_s ##0 strobe_end_s)
    else $error("strobe without single outcome");
  end_tie_a: assert property ((tx_done || tx_discard) |-> tx_stat_valid)
    else $error("outcome without vector");
  txer_disc_a: assert property (txer |-> ##[0:6] tx_discard)
    else $error("line error without discard");
  mdo_oe_a: assert property (mdo |-> mdo_en)
    else $error("mdo without enable");
endmodule : tx_mac_client_status_checker

bind tx_mac_client_status tx_mac_client_status_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .tx_fifoempty(tx_fifoempty), .tx_fifo_rd(tx_fifo_rd), .tx_stat_valid(tx_stat_valid),
  .tx_statvec(tx_statvec), .tx_done(tx_done), .tx_discard(tx_discard), .txer(txer),
  .mdo(mdo), .mdo_en(mdo_en));

/* tb/tx_fifo_model.sv */
`timescale 1ns/10ps
module tx_fifo_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fifo port
  input wire logic rd,
  output logic [7:0] data,
  output logic eof,
  output logic empty,
  output logic avail
);
  logic [8:0] q[$];
  logic [8:0] last = 9'h000;
  initial upd();
  // an empty fifo shows the inverse of the last entry, not a stale copy
  task upd();
    empty <= (q.size() == 0);
    avail <= (q.size() != 0);
    if (q.size() == 0) {eof, data} <= ~last;
    else {eof, data} <= q[0];
  endtask : upd
  task push(input logic [8:0] v);
    q.push_back(v);
    upd();
  endtask : push
  task flush();
    q.delete();
    upd();
  endtask : flush
  always @(posedge sys_clk) begin
    if (!rst && rd && q.size() != 0) begin
      last = q.pop_front();
      upd();
    end
  end
endmodule : tx_fifo_model

/* tb/tx_mac_client_status_test.sv */
`timescale 1ns/10ps
`include "tx_mac_client_status_cfg.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tx_mac_client_status_test;
  // ****
  // signals
  // ****
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic tx_fifoctrl = 1'b0;
  logic tx_defer_req = 1'b0;
  logic mdi = 1'b0;
  logic ce = 1'b1;
  logic [7:0] lb;
  logic [31:0] prdata, rdat;
  logic [7:0] tx_fifodata, txd;
  logic pready, pslverr, tx_fifoavail, tx_fifoeof, tx_fifoempty, tx_fifo_rd;
  logic tx_stat_valid, tx_done, tx_discard, txen, txer, mdo, mdo_en, mdc, irq, serr, dn, ds, vl, ctl, fcs_off;
  tx_mac_client_status_pkg::tx_statvec_s tx_statvec, ev;
  int n_errors = 0;
  int n_tests = 0;
  int len, kind, dly, j;
  int dtab[3] = '{0, 3, 20};
  always #5 sys_clk = ~sys_clk;
  tx_mac_client_status #(.EXC_DEFER_CYC(16'h0008)) DUT (.sys_clk, .rst, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_fifodata, .tx_fifoavail, .tx_fifoeof,
    .tx_fifoempty, .tx_fifoctrl, .tx_fifo_rd, .tx_defer_req, .tx_stat_valid, .tx_statvec, .tx_done,
    .tx_discard, .txd, .txen, .txer, .mdi, .mdo, .mdo_en, .mdc, .irq);
  tx_fifo_model m (.sys_clk, .rst, .rd(tx_fifo_rd), .data(tx_fifodata), .eof(tx_fifoeof),
    .empty(tx_fifoempty), .avail(tx_fifoavail));
  // ****
  // tasks
  // ****
  task final_report();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task tmo();
    n_errors++;
    $display("[FAIL] %0t got %h exp %h", $time, 0, 1);
    final_report();
  endtask : tmo
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i == 20) tmo();
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task frame(input logic last);
    int i;
    logic [7:0] b;
    @(posedge sys_clk);
    tx_defer_req <= (dly > 0);
    tx_fifoctrl <= ctl;
    for (i = 0; i < len; i++) begin
      b = 8'($urandom);
      if (i == 0) b = (kind == 0) ? 8'h02 : 8'h01;
      if (i < 6 && kind == 2) b = 8'hff;
      if (i == 12) b = vl ? 8'h81 : 8'h08;
      if (i == 13) b = 8'h00;
      m.push({last && i == len - 1, b});
    end
    lb = b;
    repeat (dly) @(posedge sys_clk);
    tx_defer_req <= 1'b0;
    i = 0;
    while (tx_stat_valid !== 1'b1 && i < 4000) begin
      @(posedge sys_clk);
      i++;
    end
    if (i == 4000) tmo();
    ev = tx_statvec;
    dn = tx_done;
    ds = tx_discard;
  endtask : frame
  function automatic tx_mac_client_status_pkg::tx_statvec_s expect_vec();
    tx_mac_client_status_pkg::tx_statvec_s e;
    e = '0;
    e.ucast = (kind == 0);
    e.mcast = (kind == 1);
    e.bcast = (kind == 2);
    e.jumbo = (len > 1518);
    e.pause = ctl;
    e.vlan = vl;
    e.byte_cnt = 14'(len);
    e.deferred = (dly > 0);
    e.exc_defer = (dly > 8);
    e.short_nofcs = (len < 64) && fcs_off;
    return e;
  endfunction : expect_vec
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(48));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `TXS_CTRL_OFS, 32'h0);
    `CHK(rdat[1:0], `TXS_CTRL_RST)
    apb(1'b0, 12'h018, 32'h0);
    `CHK({serr, rdat}, 33'h100000000)
    apb(1'b1, `TXS_MGMT_OFS, 32'h3);
    // clock enable low must freeze the pins that the write would move
    ce <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK({mdc, mdo_en, mdo}, 3'h0)
    ce <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK({mdc, mdo_en, mdo}, 3'h3)
    apb(1'b1, `TXS_MGMT_OFS, 32'h5);
    mdi <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK({mdc, mdo_en, mdo}, 3'h4)
    apb(1'b0, `TXS_MGMT_OFS, 32'h0);
    `CHK(rdat[3:0], 4'hd)
    $display("test mgmt done");
    apb(1'b1, `TXS_IRQ_MASK_OFS, 32'h7);
    // short frame and jumbo first, then random traffic
    for (j = 0; j < 10; j++) begin
      len = (j == 0) ? 20 : (j == 1) ? 1519 : 64 + $urandom % 40;
      kind = (j < 2) ? j + 1 : $urandom % 3;
      vl = 1'($urandom);
      ctl = 1'($urandom);
      dly = dtab[$urandom % 3];
      fcs_off = (j == 0);
      apb(1'b1, `TXS_CTRL_OFS, {30'h0, fcs_off, 1'b1});
      frame(1'b1);
      `CHK(ev, expect_vec())
      `CHK({dn, ds}, 2'h2)
      `CHK({txen, txd}, {1'b0, lb})
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'b1)
      apb(1'b0, `TXS_IRQ_STAT_OFS, 32'h0);
      `CHK(rdat[2:0], 3'h5)
      apb(1'b0, `TXS_LAST_VEC_OFS, 32'h0);
      `CHK(rdat, expect_vec())
      apb(1'b0, `TXS_FRAME_CNT_OFS, 32'h0);
      `CHK(rdat, j + 1)
      apb(1'b1, `TXS_IRQ_STAT_OFS, 32'h7);
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'b0)
    end
    $display("test frames done");
    apb(1'b1, `TXS_IRQ_MASK_OFS, 32'h0);
    len = 3;
    kind = 0;
    dly = 0;
    frame(1'b0);
    `CHK({dn, ds, ev.underrun}, 3'h3)
    `CHK({txen, txd}, {1'b0, lb})
    m.flush();
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    apb(1'b0, `TXS_IRQ_STAT_OFS, 32'h0);
    `CHK(rdat[2:0], 3'h6)
    apb(1'b0, `TXS_FRAME_CNT_OFS, 32'h0);
    `CHK(rdat, 32'h0000000b)
    $display("test underrun done");
    // with the enable bit clear a waiting frame must stay untouched
    apb(1'b1, `TXS_CTRL_OFS, 32'h0);
    m.push(9'h1ff);
    repeat (20) @(posedge sys_clk);
    `CHK({tx_fifoempty, txen}, 2'h0)
    $display("test disable done");
    final_report();
  end
endmodule : tx_mac_client_status_test
